// ### hw/uvs_map.svh
// Register offsets, reset values and timing counts of the undervoltage stage.
`ifndef UVS_MAP_SVH
`define UVS_MAP_SVH
`define UVS_CLK_NS       25
`define UVS_TICK_NS      5000000
`define UVS_TICK_CYC     (`UVS_TICK_NS / `UVS_CLK_NS)
`define UVS_STEP_MS      5
`define UVS_DLY_MAX_MS   1800000
`define UVS_DLY_MAX      (`UVS_DLY_MAX_MS / `UVS_STEP_MS)
`define UVS_DLY_DEF_MS   40
`define UVS_DLY_DEF      (`UVS_DLY_DEF_MS / `UVS_STEP_MS)
`define UVS_DIAL_DEF     13'h0005
`define UVS_MULT_DEF     12'h064
`define UVS_USET_DEF     16'h1770
`define UVS_UBLK_DEF     16'h03e8
`define UVS_VTP_DEF      24'h030d40
`define UVS_MODE_DEF     2'h1
`define UVS_HYST_PCT     103
`define UVS_ONE_Q16      32'h00010000
`define UVS_EXP_MAX      25
`define UVS_A_CTRL       8'h00
`define UVS_A_DELAY      8'h04
`define UVS_A_DIAL       8'h08
`define UVS_A_MULT       8'h0c
`define UVS_A_USET       8'h10
`define UVS_A_UBLK       8'h14
`define UVS_A_VTP        8'h18
`define UVS_A_STATUS     8'h1c
`define UVS_A_EXPT       8'h20
`define UVS_A_REMAIN     8'h24
`define UVS_A_RAT_A      8'h28
`define UVS_A_RAT_B      8'h2c
`define UVS_A_RAT_C      8'h30
`define UVS_A_RAT_MIN    8'h34
`define UVS_A_PU_PRIM    8'h38
`define UVS_A_BLK_PRIM   8'h3c
`endif

// ### hw/uvs_pkg.sv
// Types shared by the undervoltage stage modules.
package uvs_pkg;
  typedef enum logic [1:0] {
    UVS_MODE_DT   = 2'h1,
    UVS_MODE_INVERSE_TIME_MODE = 2'h2
  } uvs_mode_t;
  typedef enum logic [1:0] {
    UVS_S_IDLE = 2'h0,
    UVS_S_RAT  = 2'h1,
    UVS_S_POW  = 2'h2,
    UVS_S_TDIV = 2'h3
  } uvs_seq_t;
endpackage

// ### hw/uvs_div.sv
// Sequential restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module uvs_div #(
  parameter int unsigned W = 32
) (
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // Operands and start pulse.
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_num,
  input  wire logic [W-1:0] i_den,
  // Result.
  output logic              o_done,
  output logic [W-1:0]      o_quot
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0]  rem_reg;
  logic [W-1:0]  q_reg;
  logic [CW-1:0] cnt_reg;
  logic          busy_reg;
  logic [W:0]    sh;
  logic          fits;

  if (W < 2) begin : g_chk
    $error("uvs_div needs W of at least 2");
  end

  always_comb begin
    sh   = {rem_reg, q_reg[W-1]};
    fits = (sh >= {1'b0, i_den});
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rem_reg  <= '0;
      q_reg    <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      o_done   <= 1'b0;
    end else if (i_start) begin
      rem_reg  <= '0;
      q_reg    <= i_num;
      cnt_reg  <= CW'(W);
      busy_reg <= 1'b1;
      o_done   <= 1'b0;
    end else if (busy_reg) begin
      rem_reg  <= fits ? W'(sh - {1'b0, i_den}) : sh[W-1:0];
      q_reg    <= {q_reg[W-2:0], fits};
      cnt_reg  <= cnt_reg - 1'b1;
      busy_reg <= (cnt_reg != CW'(1));
      o_done   <= (cnt_reg == CW'(1));
    end else begin
      o_done   <= 1'b0;
    end
  end

  assign o_quot = q_reg;
endmodule
`default_nettype wire

// ### hw/uvs_stage.sv
// Undervoltage stage: pick-up, blocking, timing, read-back and AHB registers.
// Notes on behaviour
// - Blocking input is sampled on each processing tick.
// - Unblocked pick-up asserts start and starts timing.
// - Blocked pick-up asserts blocked, never start.
// - Blocking drops start as on pick-up release.
// - Blocking raises display and stamped block events.
// - Instant operation trips together with start unless the undervoltage block latch is set.
// - Fixed mode trips after delay, any depth unless the undervoltage block latch is set.
// - Inverse time is dial over one minus ratio-power.
// - Mode 1 fixed, 2 inverse, fixed after reset.
// - Fixed delay 0 to 1800 s, 5 ms steps.
// - Zero fixed delay means instant stage.
// - Dial 0.01 to 60 s, inverse mode only.
// - Signed time remaining shown while counting.
// - Ratios of three voltages and lowest shown.
// - Below block level trips are suppressed until recovery.
// - Primary pick-up and block levels in 0.1 V.
// - Release threshold is 103 percent of pick-up.
// - Start, trip, blocked outputs with on/off events.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "uvs_map.svh"
module uvs_stage import uvs_pkg::*; #(
  parameter int unsigned TICK_CYC = `UVS_TICK_CYC
) (
  // Clock and reset.
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_NRST,
  // AHB-Lite slave.
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // Measured voltages in 0.01 percent of nominal, and blocking.
  input  wire logic [15:0] I_VOLT_A,
  input  wire logic [15:0] I_VOLT_B,
  input  wire logic [15:0] I_VOLT_C,
  input  wire logic        I_BLOCK,
  // Stage outputs.
  output logic             O_START,
  output logic             O_TRIP,
  output logic             O_BLOCKED,
  output logic             O_UV_BLOCK,
  // Events: bit 0 start, bit 1 trip, bit 2 blocked.
  output logic      [2:0]  O_EVT_ON,
  output logic      [2:0]  O_EVT_OFF,
  output logic             O_EVT_DISPLAY,
  output logic      [31:0] O_EVT_STAMP,
  output logic      [15:0] O_EVT_VOLT_A,
  output logic      [15:0] O_EVT_VOLT_B,
  output logic      [15:0] O_EVT_VOLT_C,
  output logic      [2:0]  O_EVT_FAULT
);
  localparam logic [18:0] DLY_MAX = 19'(`UVS_DLY_MAX);

  if (TICK_CYC < 512) begin : g_chk
    $error("TICK_CYC must leave room for the ratio computation");
  end

  function automatic logic [15:0] min3(input logic [15:0] a, b, c);
    logic [15:0] m;
    m = (a < b) ? a : b;
    return (m < c) ? m : c;
  endfunction

  function automatic logic [31:0] prim(input logic [15:0] s,
                                       input logic [23:0] vt);
    logic [39:0] p;
    p = 40'(s) * 40'(vt);
    return 32'(p / 40'd10000);
  endfunction

  logic [31:0] tick_cnt_reg;
  logic        tick;
  logic [1:0]  mode_reg;
  logic [18:0] dly_reg;
  logic [12:0] dial_reg;
  logic [11:0] mult_reg;
  logic [15:0] uset_reg;
  logic [15:0] ublk_reg;
  logic [23:0] vtp_reg;
  logic        pu_reg;
  logic        pu_next;
  logic        uvb_reg;
  logic        uvb_next;
  logic        start_reg;
  logic        trip_reg;
  logic        blocked_reg;
  logic [2:0]  prv_reg;
  logic [18:0] timer_reg;
  logic [31:0] stamp_reg;
  logic [15:0] vmin;
  logic [16:0] rel_lvl;
  logic        instant;
  logic [18:0] exp_time;
  logic [19:0] remain;
  logic [18:0] exp_inverse_time_mode_reg;
  logic [16:0] rat_reg [4];
  uvs_seq_t    seq_reg;
  logic [2:0]  job_reg;
  logic [31:0] r_reg;
  logic [31:0] p_reg;
  logic [4:0]  pcnt_reg;
  logic [4:0]  a_int;
  logic        div_go_reg;
  logic [31:0] div_num;
  logic [31:0] div_den;
  logic        div_done;
  logic [31:0] div_q;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rd_mux;
  logic        acc;

  // Processing tick every 5 ms; all stage timing advances on it.
  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST || tick) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick_cnt_reg + 32'h1;
    if (!I_NRST) stamp_reg <= '0;
    else if (tick) stamp_reg <= stamp_reg + 32'h1;
  end

  // Pick-up with hysteresis and undervoltage block latch.
  always_comb begin
    vmin     = min3(I_VOLT_A, I_VOLT_B, I_VOLT_C);
    rel_lvl  = 17'((32'(uset_reg) * `UVS_HYST_PCT) / 100);
    pu_next  = pu_reg ? ({1'b0, vmin} <= rel_lvl) : (vmin < uset_reg);
    uvb_next = (ublk_reg != 16'h0) && (uvb_reg ? (vmin <= uset_reg)
                                               : (vmin < ublk_reg));
    instant  = (mode_reg == UVS_MODE_DT) && (dly_reg == 19'h0);
    exp_time = (mode_reg == UVS_MODE_INVERSE_TIME_MODE) ? exp_inverse_time_mode_reg
                                           : dly_reg;
    remain   = start_reg ? 20'({1'b0, exp_time} - {1'b0, timer_reg})
                         : 20'h0;
  end

  // Stage decision on each tick.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      pu_reg      <= 1'b0;
      uvb_reg     <= 1'b0;
      start_reg   <= 1'b0;
      trip_reg    <= 1'b0;
      blocked_reg <= 1'b0;
      timer_reg   <= '0;
    end else if (tick) begin
      pu_reg  <= pu_next;
      uvb_reg <= uvb_next;
      if (!pu_next) begin
        start_reg   <= 1'b0;
        trip_reg    <= 1'b0;
        blocked_reg <= 1'b0;
        timer_reg   <= '0;
      end else if (I_BLOCK) begin
        blocked_reg <= 1'b1;
        start_reg   <= 1'b0;
        trip_reg    <= 1'b0;
        timer_reg   <= '0;
      end else if (!start_reg) begin
        blocked_reg <= 1'b0;
        start_reg   <= 1'b1;
        timer_reg   <= '0;
        trip_reg    <= instant && !uvb_next;
      end else begin
        if (timer_reg < DLY_MAX) timer_reg <= timer_reg + 19'h1;
        if ((timer_reg + 19'h1 >= exp_time) && !uvb_next)
          trip_reg <= 1'b1;
      end
    end
  end

  // Edge events, voltages and fault type captured when the fault is first seen, and the stamp taken on every tick.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      prv_reg      <= '0;
      O_EVT_STAMP  <= '0;
      O_EVT_VOLT_A <= '0;
      O_EVT_VOLT_B <= '0;
      O_EVT_VOLT_C <= '0;
      O_EVT_FAULT  <= '0;
    end else begin
      prv_reg <= {blocked_reg, trip_reg, start_reg};
      if (tick && pu_next && !pu_reg) begin
        O_EVT_VOLT_A <= I_VOLT_A;
        O_EVT_VOLT_B <= I_VOLT_B;
        O_EVT_VOLT_C <= I_VOLT_C;
        O_EVT_FAULT  <= {I_VOLT_C < uset_reg, I_VOLT_B < uset_reg,
                         I_VOLT_A < uset_reg};
      end
      if (tick) O_EVT_STAMP <= stamp_reg;
    end
  end
  assign O_EVT_ON      = {blocked_reg, trip_reg, start_reg} & ~prv_reg;
  assign O_EVT_OFF     = ~{blocked_reg, trip_reg, start_reg} & prv_reg;
  assign O_EVT_DISPLAY = blocked_reg & ~prv_reg[2];
  assign O_START       = start_reg;
  assign O_TRIP        = trip_reg;
  assign O_BLOCKED     = blocked_reg;
  assign O_UV_BLOCK    = uvb_reg;

  // Ratio and inverse-time sequencer; one divider serves all jobs.
  assign a_int = ({1'b0, mult_reg} + 13'd50 >= 13'(`UVS_EXP_MAX * 100)) ?
                 5'(`UVS_EXP_MAX) : 5'(({1'b0, mult_reg} + 13'd50) / 13'd100);
  always_comb begin
    div_den = 32'(uset_reg);
    unique case (job_reg)
      3'h0:    div_num = 32'(I_VOLT_A) * 32'd100;
      3'h1:    div_num = 32'(I_VOLT_B) * 32'd100;
      3'h2:    div_num = 32'(I_VOLT_C) * 32'd100;
      3'h3:    div_num = 32'(vmin) * 32'd100;
      default: div_num = {vmin, 16'h0};
    endcase
    if (seq_reg == UVS_S_TDIV) begin
      div_num = {2'h0, dial_reg, 1'b0, 16'h0};
      div_den = `UVS_ONE_Q16 - p_reg;
    end
  end

  uvs_div #(.W(32)) u_div (
    .i_clk   (I_CLK_SYS),
    .i_nrst  (I_NRST),
    .i_start (div_go_reg),
    .i_num   (div_num),
    .i_den   (div_den),
    .o_done  (div_done),
    .o_quot  (div_q)
  );

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      seq_reg      <= UVS_S_IDLE;
      job_reg      <= '0;
      div_go_reg   <= 1'b0;
      r_reg        <= '0;
      p_reg        <= '0;
      pcnt_reg     <= '0;
      exp_inverse_time_mode_reg <= DLY_MAX;
      for (int i = 0; i < 4; i++) rat_reg[i] <= '0;
    end else begin
      div_go_reg <= 1'b0;
      unique case (seq_reg)
        UVS_S_IDLE: if (tick) begin
          seq_reg    <= UVS_S_RAT;
          job_reg    <= 3'h0;
          div_go_reg <= 1'b1;
        end
        UVS_S_RAT: if (div_done) begin
          if (job_reg < 3'h4) begin
            rat_reg[job_reg[1:0]] <= (div_q > 32'h1ffff) ? 17'h1ffff
                                                         : div_q[16:0];
            job_reg    <= job_reg + 3'h1;
            div_go_reg <= 1'b1;
          end else if (div_q >= `UVS_ONE_Q16) begin
            exp_inverse_time_mode_reg <= DLY_MAX;
            seq_reg      <= UVS_S_IDLE;
          end else begin
            r_reg    <= div_q;
            p_reg    <= div_q;
            pcnt_reg <= (a_int == 5'h0) ? 5'h0 : a_int - 5'h1;
            seq_reg  <= UVS_S_POW;
          end
        end
        UVS_S_POW: if (pcnt_reg == 5'h0) begin
          seq_reg    <= UVS_S_TDIV;
          div_go_reg <= 1'b1;
        end else begin
          p_reg    <= 32'((64'(p_reg) * 64'(r_reg)) >> 16);
          pcnt_reg <= pcnt_reg - 5'h1;
        end
        UVS_S_TDIV: if (div_done) begin
          exp_inverse_time_mode_reg <= (div_q > 32'(DLY_MAX)) ? DLY_MAX : div_q[18:0];
          seq_reg      <= UVS_S_IDLE;
        end
      endcase
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY.
  assign acc         = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  always_comb begin
    unique case (I_HADDR[7:0])
      `UVS_A_CTRL:     rd_mux = 32'(mode_reg);
      `UVS_A_DELAY:    rd_mux = 32'(dly_reg);
      `UVS_A_DIAL:     rd_mux = 32'(dial_reg);
      `UVS_A_MULT:     rd_mux = 32'(mult_reg);
      `UVS_A_USET:     rd_mux = 32'(uset_reg);
      `UVS_A_UBLK:     rd_mux = 32'(ublk_reg);
      `UVS_A_VTP:      rd_mux = 32'(vtp_reg);
      `UVS_A_STATUS:   rd_mux = {27'h0, pu_reg, uvb_reg, blocked_reg,
                                 trip_reg, start_reg};
      `UVS_A_EXPT:     rd_mux = 32'(exp_time);
      `UVS_A_REMAIN:   rd_mux = {{12{remain[19]}}, remain};
      `UVS_A_RAT_A:    rd_mux = 32'(rat_reg[0]);
      `UVS_A_RAT_B:    rd_mux = 32'(rat_reg[1]);
      `UVS_A_RAT_C:    rd_mux = 32'(rat_reg[2]);
      `UVS_A_RAT_MIN:  rd_mux = 32'(rat_reg[3]);
      `UVS_A_PU_PRIM:  rd_mux = prim(uset_reg, vtp_reg);
      `UVS_A_BLK_PRIM: rd_mux = prim(ublk_reg, vtp_reg);
      default:         rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      O_HRDATA    <= '0;
    end else begin
      wr_pend_reg <= acc && I_HWRITE;
      if (acc) wr_addr_reg <= I_HADDR[7:0];
      if (acc && !I_HWRITE) O_HRDATA <= rd_mux;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      mode_reg <= `UVS_MODE_DEF;
      dly_reg  <= 19'(`UVS_DLY_DEF);
      dial_reg <= `UVS_DIAL_DEF;
      mult_reg <= `UVS_MULT_DEF;
      uset_reg <= `UVS_USET_DEF;
      ublk_reg <= `UVS_UBLK_DEF;
      vtp_reg  <= `UVS_VTP_DEF;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `UVS_A_CTRL:  if (I_HWDATA[1:0] == UVS_MODE_DT ||
                          I_HWDATA[1:0] == UVS_MODE_INVERSE_TIME_MODE)
                        mode_reg <= I_HWDATA[1:0];
        `UVS_A_DELAY: dly_reg <= (I_HWDATA > 32'(DLY_MAX)) ? DLY_MAX
                                 : I_HWDATA[18:0];
        `UVS_A_DIAL:  if (I_HWDATA >= 32'h1 && I_HWDATA <= 32'd6000)
                        dial_reg <= I_HWDATA[12:0];
        `UVS_A_MULT:  mult_reg <= I_HWDATA[11:0];
        `UVS_A_USET:  uset_reg <= I_HWDATA[15:0];
        `UVS_A_UBLK:  ublk_reg <= I_HWDATA[15:0];
        `UVS_A_VTP:   vtp_reg  <= I_HWDATA[23:0];
        default:      ;
      endcase
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);

  start_vs_blk_a: assert property (!(start_reg && blocked_reg))
    else $error("start and blocked both active");
  blk_drop_a: assert property (tick && pu_next && I_BLOCK
      |=> !start_reg && blocked_reg)
    else $error("blocking did not drop start");
  start_go_a: assert property (tick && pu_next && !I_BLOCK && !start_reg
      |=> start_reg)
    else $error("start not raised on pick-up");
  inst_trip_a: assert property (tick && pu_next && !I_BLOCK && !start_reg
      && instant && !uvb_next |=> trip_reg && start_reg)
    else $error("instant stage did not trip with start");
  dt_wait_a: assert property ($rose(trip_reg) && mode_reg == UVS_MODE_DT
      && dly_reg != 19'h0 |-> timer_reg >= dly_reg)
    else $error("fixed delay trip came early");
  uvb_trip_a: assert property ($rose(trip_reg) |-> !uvb_reg)
    else $error("trip while network de-energized");
  tick_only_a: assert property (!tick |=> $stable(start_reg)
      && $stable(trip_reg) && $stable(blocked_reg))
    else $error("stage state changed off the tick");
  hyst_hold_a: assert property (tick && pu_reg
      && {1'b0, vmin} <= rel_lvl |=> pu_reg)
    else $error("pick-up released inside hysteresis");
  disp_evt_a: assert property (tick && pu_next && I_BLOCK && !blocked_reg
      |=> O_EVT_DISPLAY && O_EVT_ON[2])
    else $error("blocking raised no event");
endmodule
`default_nettype wire

// ### test/uvs_front_model.sv
// Behavioural voltage front end and blocking matrix facing the stage.
`timescale 1ns/1ps
`default_nettype none
module uvs_front_model (
  // Clock.
  input  wire logic        i_clk,
  // Levels commanded by the bench.
  input  wire logic [15:0] i_set_a,
  input  wire logic [15:0] i_set_b,
  input  wire logic [15:0] i_set_c,
  input  wire logic        i_set_blk,
  // Lines into the stage.
  output logic      [15:0] o_volt_a = 16'h2710,
  output logic      [15:0] o_volt_b = 16'h2710,
  output logic      [15:0] o_volt_c = 16'h2710,
  output logic             o_block = 1'b0
);
  // The measurement path presents each level one clock after it is set.
  always @(posedge i_clk) begin
    o_volt_a <= i_set_a;
    o_volt_b <= i_set_b;
    o_volt_c <= i_set_c;
  end
  // A block ordered a whole tick ahead reaches the stage before the delay ends.
  always @(posedge i_clk) begin
    o_block <= i_set_blk;
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench of the undervoltage stage.
`timescale 1ns/1ps
`default_nettype none
`include "uvs_map.svh"
module tb_top;
  localparam int unsigned TICKS = 512;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] cva = 16'h2710;
  logic [15:0] cvb = 16'h2710;
  logic [15:0] cvc = 16'h2710;
  logic        cblk = 1'b0;
  wire  logic [15:0] va, vb, vc;
  wire  logic        blk;
  logic [31:0] hrdata, stamp;
  logic        hready, hresp, start, trip, blocked, uvblk, evt_disp;
  logic [2:0]  evt_on, evt_off, evt_fault;
  logic [15:0] eva, evb, evc;
  int          bad_count = 0;
  int          comparisons = 0;
  logic [31:0] lfsr = 32'h0a3c5abf;
  wire  logic [2:0] outs = {blocked, trip, start};

  always #12.5 clk = ~clk;

  uvs_front_model model (.i_clk(clk), .i_set_a(cva), .i_set_b(cvb),
    .i_set_c(cvc), .i_set_blk(cblk), .o_volt_a(va), .o_volt_b(vb),
    .o_volt_c(vc), .o_block(blk));

  uvs_stage #(.TICK_CYC(TICKS)) dut (.I_CLK_SYS(clk), .I_NRST(nrst),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_VOLT_A(va), .I_VOLT_B(vb), .I_VOLT_C(vc), .I_BLOCK(blk),
    .O_START(start), .O_TRIP(trip), .O_BLOCKED(blocked),
    .O_UV_BLOCK(uvblk), .O_EVT_ON(evt_on), .O_EVT_OFF(evt_off),
    .O_EVT_DISPLAY(evt_disp), .O_EVT_STAMP(stamp), .O_EVT_VOLT_A(eva),
    .O_EVT_VOLT_B(evb), .O_EVT_VOLT_C(evc), .O_EVT_FAULT(evt_fault));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_ratio(input logic [31:0] v);
    return v * 32'h64 / 32'h1770;
  endfunction
  function automatic logic [31:0] exp_prim(input logic [31:0] set);
    return set * 32'h30d40 / 32'h2710;
  endfunction
  // Inverse operate time in 5 ms ticks for an exponent of one.
  function automatic logic [31:0] exp_inv(input logic [31:0] dial,
                                          input logic [31:0] rat);
    return dial * 32'hc8 / (32'h64 - rat);
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic ahb_xfer(input logic [7:0] a, input logic w,
                          input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    ahb_xfer(a, 1'b1, d, unused);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    ahb_xfer(a, 1'b0, 32'h0, d);
    check(name, d, exp);
    check("response", {31'h0, hresp}, 32'h0);
  endtask
  task automatic setv(input logic [15:0] a, input logic [15:0] b,
                      input logic bk);
    @(posedge clk);
    cva <= a;
    cvb <= b;
    cblk <= bk;
  endtask
  task automatic tick(input int n);
    logic [31:0] s;
    repeat (n) begin
      s = stamp;
      do begin
        @(posedge clk);
        #1;
      end while (stamp === s);
    end
  endtask
  task automatic wait_out(input int k, input logic v);
    do begin
      @(posedge clk);
      #1;
    end while (outs[k] !== v);
  endtask
  task automatic evt_scan(output logic [2:0] on_h, output logic [2:0] off_h,
                          output logic dsp_h);
    on_h = 3'h0;
    off_h = 3'h0;
    dsp_h = 1'b0;
    repeat (3) begin
      on_h = on_h | evt_on;
      off_h = off_h | evt_off;
      dsp_h = dsp_h | evt_disp;
      @(posedge clk);
      #1;
    end
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    logic [31:0] d, s0, dly, v;
    logic [2:0]  eon, eoff;
    logic        edsp;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check("outputs after reset", {28'h0, uvblk, outs}, 32'h0);
    rd_chk("mode", `UVS_A_CTRL, 32'h1);
    rd_chk("delay", `UVS_A_DELAY, 32'h8);
    rd_chk("dial", `UVS_A_DIAL, 32'h5);
    rd_chk("unmapped", 8'h80, 32'h0);
    rd_chk("pickup primary", `UVS_A_PU_PRIM, exp_prim(32'h1770));
    rd_chk("block primary", `UVS_A_BLK_PRIM, exp_prim(32'h3e8));
    ahb_wr(`UVS_A_DELAY, 32'hffffff);
    rd_chk("delay ceiling", `UVS_A_DELAY, 32'h57e40);
    ahb_wr(`UVS_A_DELAY, 32'h8);
    // Fixed delay with a short block pulse that falls between ticks.
    setv(16'd3000, 16'h2710, 1'b0);
    wait_out(0, 1'b1);
    s0 = stamp;
    evt_scan(eon, eoff, edsp);
    check("start event", {31'h0, eon[0]}, 32'h1);
    check("fault type", {29'h0, evt_fault}, 32'h1);
    check("start voltage", {16'h0, eva}, 32'd3000);
    check("start voltages b c", {evb, evc}, 32'h27102710);
    // Ratios are refreshed one tick after the fault; this also parks the
    // block pulse below well clear of the next tick.
    tick(1);
    rd_chk("ratio a", `UVS_A_RAT_A, exp_ratio(32'd3000));
    rd_chk("ratio b", `UVS_A_RAT_B, exp_ratio(32'h2710));
    rd_chk("ratio min", `UVS_A_RAT_MIN, exp_ratio(32'd3000));
    rd_chk("expected time", `UVS_A_EXPT, 32'h8);
    ahb_xfer(`UVS_A_REMAIN, 1'b0, 32'h0, d);
    check("remaining", 32'(($signed(d) > 0) && ($signed(d) <= 8)), 32'h1);
    setv(16'd3000, 16'h2710, 1'b1);
    setv(16'd3000, 16'h2710, 1'b0);
    tick(1);
    check("start past pulse", {31'h0, start}, 32'h1);
    wait_out(1, 1'b1);
    check("fixed delay", stamp - s0, 32'h8);
    check("trip event", {31'h0, evt_on[1]}, 32'h1);
    setv(16'd6100, 16'h2710, 1'b0);
    tick(2);
    check("start in hysteresis", {31'h0, start}, 32'h1);
    setv(16'd6200, 16'h2710, 1'b0);
    wait_out(0, 1'b0);
    // Random depths and delays, the first one instant.
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      dly = (i == 0) ? 32'h0 : {29'h0, lfsr[2:0]} + 32'h1;
      v = 32'd1100 + {20'h0, lfsr[24:13]};
      ahb_wr(`UVS_A_DELAY, dly);
      setv(v[15:0], 16'h1b58 + {4'h0, lfsr[11:0]}, 1'b0);
      wait_out(0, 1'b1);
      s0 = stamp;
      if (dly == 32'h0) check("instant trip", {31'h0, trip}, 32'h1);
      wait_out(1, 1'b1);
      check("random delay", stamp - s0, dly);
      setv(16'h2710, 16'h2710, 1'b0);
      wait_out(0, 1'b0);
    end
    // Blocked pick-up, then release of the block, then a block on start.
    ahb_wr(`UVS_A_DELAY, 32'h8);
    setv(16'd3000, 16'h2710, 1'b1);
    wait_out(2, 1'b1);
    evt_scan(eon, eoff, edsp);
    check("no start when blocked", {31'h0, start}, 32'h0);
    check("display event", {31'h0, edsp}, 32'h1);
    check("block event", {31'h0, eon[2]}, 32'h1);
    check("block fault type", {29'h0, evt_fault}, 32'h1);
    tick(9);
    check("no trip when blocked", {30'h0, trip, start}, 32'h0);
    setv(16'd3000, 16'h2710, 1'b0);
    wait_out(0, 1'b1);
    check("block off event", {31'h0, evt_off[2]}, 32'h1);
    setv(16'd3000, 16'h2710, 1'b1);
    wait_out(0, 1'b0);
    evt_scan(eon, eoff, edsp);
    check("start off event", {31'h0, eoff[0]}, 32'h1);
    check("no trip after block", {31'h0, trip}, 32'h0);
    setv(16'h2710, 16'h2710, 1'b0);
    tick(2);
    // De-energized network holds off the trip until recovery.
    ahb_wr(`UVS_A_DELAY, 32'h1);
    setv(16'd500, 16'h2710, 1'b0);
    tick(3);
    check("dead network", {30'h0, uvblk, trip}, 32'h2);
    setv(16'd5000, 16'h2710, 1'b0);
    tick(2);
    check("still suppressed", {30'h0, uvblk, trip}, 32'h2);
    setv(16'd6100, 16'h2710, 1'b0);
    tick(2);
    check("recovered", {31'h0, uvblk}, 32'h0);
    setv(16'd5000, 16'h2710, 1'b0);
    wait_out(1, 1'b1);
    setv(16'h2710, 16'h2710, 1'b0);
    wait_out(0, 1'b0);
    // Inverse time with the voltage moving during the fault.
    ahb_wr(`UVS_A_CTRL, 32'h3);
    rd_chk("mode kept", `UVS_A_CTRL, 32'h1);
    ahb_wr(`UVS_A_CTRL, 32'h2);
    rd_chk("inverse mode", `UVS_A_CTRL, 32'h2);
    ahb_wr(`UVS_A_DIAL, 32'h2);
    setv(16'd3000, 16'h2710, 1'b0);
    wait_out(0, 1'b1);
    s0 = stamp;
    tick(1);
    rd_chk("inverse time", `UVS_A_EXPT, exp_inv(32'h2, 32'd50));
    setv(16'd4500, 16'h2710, 1'b0);
    tick(2);
    rd_chk("tracked time", `UVS_A_EXPT, exp_inv(32'h2, 32'd75));
    wait_out(1, 1'b1);
    check("inverse trip", stamp - s0, exp_inv(32'h2, 32'd75));
    conclude();
  end
endmodule
`default_nettype wire
